// file: iss_pkg.sv
// Package for the I2C slave transmit/acknowledge block and its bus master end.
// Assumes both ends share one system clock and one asynchronous active-low reset.
package iss_pkg;
	localparam int          ISS_BITS_PER_BYTE = 8;
	localparam int          ISS_ADDR_BITS     = 7;
	localparam logic [3:0]  ISS_ACK_SLOT      = 4'h8;
	localparam logic [3:0]  ISS_CNT_ZERO      = 4'h0;
	localparam logic [3:0]  ISS_CNT_ONE       = 4'h1;
	localparam logic [7:0]  ISS_BYTE_ZERO     = 8'h00;
	localparam logic [6:0]  ISS_ADDR_ZERO     = 7'h00;
	localparam logic [1:0]  ISS_SYNC_ZERO     = 2'h0;
	// Master clock divider: half period in system clocks (125 MHz -> 125 ns SCL)
	localparam real         ISS_SCL_PERIOD_NS = 125.0;
	localparam real         ISS_CLK_PERIOD_NS = 8.0;
	localparam int          ISS_HALF_CYCLES   = int'(ISS_SCL_PERIOD_NS / ISS_CLK_PERIOD_NS / 2.0);
	localparam logic [7:0]  ISS_HALF_COUNT    = 8'(ISS_HALF_CYCLES);
	localparam logic [7:0]  ISS_DIV_ZERO      = 8'h00;
	localparam logic [7:0]  ISS_DIV_ONE       = 8'h01;
	typedef enum logic [1:0] {ISS_PHASE_IDLE, ISS_PHASE_ADDR, ISS_PHASE_TX} iss_phase_t;
endpackage

// file: iss_bus_if.sv
// Interface carrying the open-drain SCL and SDA wires between the two ends.
// Assumes each end drives only output enables; a set enable pulls the wire low.
`timescale 1ns/1ns
interface iss_bus_if;
	logic slv_scl_oe;
	logic slv_sda_oe;
	logic mst_scl_oe;
	logic mst_sda_oe;
	logic scl;
	logic sda;
	// Wired-AND with pull-up: any enabled driver pulls low
	assign scl = ~(slv_scl_oe | mst_scl_oe);
	assign sda = ~(slv_sda_oe | mst_sda_oe);
	modport slave  (input scl, input sda, output slv_scl_oe, output slv_sda_oe);
	modport master (input scl, input sda, output mst_scl_oe, output mst_sda_oe);
endinterface

// file: iss_sync.sv
// Two-flop synchroniser for a level from outside the clock domain.
// Assumes the input may change at any time relative to CLK_IN.
`timescale 1ns/1ns
module iss_sync (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic resetn_in,
	// Level
	input  wire logic d_in,
	output logic      q_out
);
	import iss_pkg::*;
	logic [1:0] sync_reg;
	// First flop is read only by the second
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sync_reg <= {1'b1, 1'b1};
		end else begin
			sync_reg <= {sync_reg[0], d_in};
		end
	end
	assign q_out = sync_reg[1];
endmodule

// file: iss_slave.sv
// I2C slave end: address match, acknowledge, transmit with clock stretching, flags.
// Assumes SCL and SDA arrive asynchronously; software sits on the plain user-side ports.
`timescale 1ns/1ns
module iss_slave (
	// Clock and reset
	input  wire logic  CLK_IN,
	input  wire logic  RESETN_IN,
	// Bus
	iss_bus_if.slave   BUS,
	// Configuration
	input  wire logic [6:0] OWN_ADDR_IN,
	input  wire logic  ADDRESS_HOLD_ENABLE_IN,
	input  wire logic  DATA_HOLD_ENABLE_IN,
	input  wire logic  ACK_DATA_VALUE_IN,
	input  wire logic  SLAVE_COLLISION_DETECT_ENABLE_IN,
	input  wire logic  START_IRQ_ENABLE_IN,
	input  wire logic  RECEIVE_OVERFLOW_FLAG_IN,
	// Software strobes
	input  wire logic  BUF_WRITE_IN,
	input  wire logic [7:0] BUF_WDATA_IN,
	input  wire logic  BUF_READ_IN,
	input  wire logic  CLOCK_RELEASE_SET_IN,
	input  wire logic  IRQ_CLEAR_IN,
	input  wire logic  COLLISION_CLEAR_IN,
	// Status
	output logic [7:0] SERIAL_DATA_BUFFER_OUT,
	output logic       BUFFER_FULL_FLAG_OUT,
	output logic       ACK_STATUS_OUT,
	output logic       ACK_TIME_STATUS_OUT,
	output logic       READ_STATUS_OUT,
	output logic       START_STATUS_OUT,
	output logic       CLOCK_RELEASE_OUT,
	output logic       SERIAL_PORT_IRQ_FLAG_OUT,
	output logic       BUS_COLLISION_IRQ_FLAG_OUT
);
	import iss_pkg::*;

	// ==========================================================
	// Pin sampling and edge detection
	logic scl_s, sda_s, scl_d_reg, sda_d_reg;
	iss_sync u_scl (.clk_in(CLK_IN), .resetn_in(RESETN_IN), .d_in(BUS.scl), .q_out(scl_s));
	iss_sync u_sda (.clk_in(CLK_IN), .resetn_in(RESETN_IN), .d_in(BUS.sda), .q_out(sda_s));
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end
	logic scl_rise, scl_fall, start_det, stop_det;
	assign scl_rise  = scl_s & ~scl_d_reg;
	assign scl_fall  = ~scl_s & scl_d_reg;
	assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	// ==========================================================
	// Sequencing state
	iss_phase_t phase_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_in_reg;
	logic [7:0] shift_out_reg;
	logic       sda_oe_reg, scl_oe_reg;
	logic       hold_en, addr_match, ack_level, collision;
	assign hold_en    = ADDRESS_HOLD_ENABLE_IN | DATA_HOLD_ENABLE_IN;
	// Address is the top seven bits; bit 0 is direction
	assign addr_match = (shift_in_reg[7:1] == OWN_ADDR_IN);
	// Drive low unless full/overflow; hold modes take software level
	assign ack_level  = hold_en ? ACK_DATA_VALUE_IN : 1'b0;
	// Released-high bit seen low while transmitting: someone else drives
	assign collision  = (phase_reg == ISS_PHASE_TX) && scl_rise && (bit_cnt_reg < ISS_ACK_SLOT)
	                    && !sda_oe_reg && !sda_s;

	// Bit counter counts falling edges within a byte
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			bit_cnt_reg <= ISS_CNT_ZERO;
		end else if (start_det) begin
			// All ones: the fall that ends the Start itself wraps this to bit zero
			bit_cnt_reg <= ISS_CNT_ZERO - ISS_CNT_ONE;
		end else if (scl_fall) begin
			bit_cnt_reg <= (bit_cnt_reg == ISS_ACK_SLOT) ? ISS_CNT_ZERO : bit_cnt_reg + ISS_CNT_ONE;
		end
	end

	// Receive shifter samples SDA on rising SCL
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			shift_in_reg <= ISS_BYTE_ZERO;
		end else if (scl_rise && bit_cnt_reg < ISS_ACK_SLOT) begin
			shift_in_reg <= {shift_in_reg[6:0], sda_s};
		end
	end

	// Phase machine
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			phase_reg <= ISS_PHASE_IDLE;
		end else if (start_det) begin
			phase_reg <= ISS_PHASE_ADDR;
		end else if (stop_det) begin
			phase_reg <= ISS_PHASE_IDLE;
		end else if (collision && SLAVE_COLLISION_DETECT_ENABLE_IN) begin
			phase_reg <= ISS_PHASE_IDLE;
		end else if (scl_fall && bit_cnt_reg == ISS_ACK_SLOT) begin
			unique case (phase_reg)
				ISS_PHASE_ADDR: phase_reg <= (sda_oe_reg && READ_STATUS_OUT) ? ISS_PHASE_TX
				                                                             : ISS_PHASE_IDLE;
				ISS_PHASE_TX:   phase_reg <= ACK_STATUS_OUT ? ISS_PHASE_IDLE : ISS_PHASE_TX;
				ISS_PHASE_IDLE: phase_reg <= ISS_PHASE_IDLE;
			endcase
		end
	end

	// ==========================================================
	// SDA drive: open drain only, acknowledge or data low bits
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			sda_oe_reg <= 1'b0;
		end else if (start_det || stop_det || (collision && SLAVE_COLLISION_DETECT_ENABLE_IN)) begin
			sda_oe_reg <= 1'b0;
		end else if (scl_fall) begin
			if (phase_reg == ISS_PHASE_ADDR && bit_cnt_reg == ISS_CNT_ZERO + 4'h7 && addr_match
			    && !BUFFER_FULL_FLAG_OUT && !RECEIVE_OVERFLOW_FLAG_IN) begin
				sda_oe_reg <= ~ack_level;
			end else if (phase_reg == ISS_PHASE_TX && bit_cnt_reg < ISS_ACK_SLOT - ISS_CNT_ONE) begin
				sda_oe_reg <= ~shift_out_reg[3'(ISS_CNT_ZERO + 4'h6 - bit_cnt_reg)];
			end else begin
				sda_oe_reg <= 1'b0;
			end
		end else if (scl_oe_reg && phase_reg == ISS_PHASE_TX) begin
			// While stretched, SDA follows the shifter MSB so the load before release is seen
			sda_oe_reg <= ~shift_out_reg[ISS_BITS_PER_BYTE - 1];
		end
	end

	// Transmit shifter loaded by buffer write
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			shift_out_reg <= ISS_BYTE_ZERO;
		end else if (BUF_WRITE_IN) begin
			shift_out_reg <= BUF_WDATA_IN;
		end
	end

	// ==========================================================
	// Software-visible buffer, status and flags
	logic ack_slot_fall;
	assign ack_slot_fall = scl_fall && bit_cnt_reg == ISS_ACK_SLOT && phase_reg != ISS_PHASE_IDLE;
	logic addr_ack_fall;
	assign addr_ack_fall = scl_fall && bit_cnt_reg == ISS_CNT_ZERO + 4'h7
	                       && phase_reg == ISS_PHASE_ADDR && addr_match;

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			SERIAL_DATA_BUFFER_OUT <= ISS_BYTE_ZERO;
			BUFFER_FULL_FLAG_OUT   <= 1'b0;
			READ_STATUS_OUT        <= 1'b0;
		end else begin
			if (BUF_WRITE_IN) begin
				SERIAL_DATA_BUFFER_OUT <= BUF_WDATA_IN;
			end
			if (addr_ack_fall && !BUFFER_FULL_FLAG_OUT) begin
				SERIAL_DATA_BUFFER_OUT <= shift_in_reg;
				READ_STATUS_OUT        <= shift_in_reg[0];
				BUFFER_FULL_FLAG_OUT   <= 1'b1;
			end else if (BUF_READ_IN) begin
				BUFFER_FULL_FLAG_OUT   <= 1'b0;
			end
		end
	end

	// Acknowledge status sampled on the ninth rising edge
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			ACK_STATUS_OUT <= 1'b0;
		end else if (scl_rise && bit_cnt_reg == ISS_ACK_SLOT && phase_reg == ISS_PHASE_TX) begin
			ACK_STATUS_OUT <= sda_s;
		end
	end

	// Ack-time status from eighth fall to ninth fall of a matched address byte, hold modes only
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			ACK_TIME_STATUS_OUT <= 1'b0;
		end else if (addr_ack_fall && hold_en) begin
			ACK_TIME_STATUS_OUT <= 1'b1;
		end else if (scl_fall || start_det || stop_det) begin
			ACK_TIME_STATUS_OUT <= 1'b0;
		end
	end

	// Start status follows the last condition seen
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			START_STATUS_OUT <= 1'b0;
		end else if (start_det) begin
			START_STATUS_OUT <= 1'b1;
		end else if (stop_det) begin
			START_STATUS_OUT <= 1'b0;
		end
	end

	// Clock stretching: hold SCL low after ninth fall until software releases
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			scl_oe_reg        <= 1'b0;
			CLOCK_RELEASE_OUT <= 1'b1;
		end else if (start_det || stop_det) begin
			scl_oe_reg        <= 1'b0;
			CLOCK_RELEASE_OUT <= 1'b1;
		end else if ((addr_ack_fall && shift_in_reg[0] && !BUFFER_FULL_FLAG_OUT)
		             ? 1'b0 : (ack_slot_fall && ((phase_reg == ISS_PHASE_ADDR && sda_oe_reg
		             && READ_STATUS_OUT) || (phase_reg == ISS_PHASE_TX && !ACK_STATUS_OUT)))) begin
			scl_oe_reg        <= 1'b1;
			CLOCK_RELEASE_OUT <= 1'b0;
		end else if (CLOCK_RELEASE_SET_IN) begin
			scl_oe_reg        <= 1'b0;
			CLOCK_RELEASE_OUT <= 1'b1;
		end
	end

	// Sticky interrupt flags; a set in the clearing cycle wins
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			SERIAL_PORT_IRQ_FLAG_OUT   <= 1'b0;
			BUS_COLLISION_IRQ_FLAG_OUT <= 1'b0;
		end else begin
			if (ack_slot_fall || (start_det && START_IRQ_ENABLE_IN)) begin
				SERIAL_PORT_IRQ_FLAG_OUT <= 1'b1;
			end else if (IRQ_CLEAR_IN) begin
				SERIAL_PORT_IRQ_FLAG_OUT <= 1'b0;
			end
			if (collision && SLAVE_COLLISION_DETECT_ENABLE_IN) begin
				BUS_COLLISION_IRQ_FLAG_OUT <= 1'b1;
			end else if (COLLISION_CLEAR_IN) begin
				BUS_COLLISION_IRQ_FLAG_OUT <= 1'b0;
			end
		end
	end

	assign BUS.slv_sda_oe = sda_oe_reg;
	assign BUS.slv_scl_oe = scl_oe_reg;
endmodule

// file: iss_master.sv
// I2C bus master end: issues Start, address with read bit, clocks bytes, acks, Stop.
// Assumes the user pulses a request; SCL is made here by a divider of CLK_IN.
`timescale 1ns/1ns
module iss_master (
	// Clock and reset
	input  wire logic  CLK_IN,
	input  wire logic  RESETN_IN,
	// Bus
	iss_bus_if.master  BUS,
	// User request
	input  wire logic  READ_REQ_IN,
	input  wire logic [6:0] ADDR_IN,
	input  wire logic  ACK_BYTE_IN,
	input  wire logic  STOP_REQ_IN,
	// Result
	output logic [7:0] RDATA_OUT,
	output logic       RDATA_VALID_OUT,
	output logic       ADDR_NACK_OUT,
	output logic       BUSY_OUT
);
	import iss_pkg::*;
	typedef enum logic [2:0] {ISM_IDLE, ISM_START, ISM_BITS, ISM_STOP} iss_mst_state_t;
	iss_mst_state_t state_reg;
	logic [7:0] div_reg;
	logic [3:0] bit_reg;
	logic [7:0] sh_reg;
	logic       phase_reg, is_addr_reg, ack_reg, scl_oe_reg, sda_oe_reg;
	logic       scl_s, sda_s, tick;
	iss_sync u_scl (.clk_in(CLK_IN), .resetn_in(RESETN_IN), .d_in(BUS.scl), .q_out(scl_s));
	iss_sync u_sda (.clk_in(CLK_IN), .resetn_in(RESETN_IN), .d_in(BUS.sda), .q_out(sda_s));
	// ==========================================================
	// Divider halts while a stretched SCL stays low
	assign tick = (div_reg == ISS_HALF_COUNT) && !(phase_reg && !scl_oe_reg && !scl_s);
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			div_reg <= ISS_DIV_ZERO;
		end else if (state_reg == ISM_IDLE || tick || (phase_reg && !scl_oe_reg && !scl_s)) begin
			// A full high half is counted only once SCL is really seen high
			div_reg <= ISS_DIV_ZERO;
		end else if (div_reg != ISS_HALF_COUNT) begin
			div_reg <= div_reg + ISS_DIV_ONE;
		end
	end
	// ==========================================================
	// Sequencer: phase 0 = SCL low half, phase 1 = SCL high half
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			state_reg <= ISM_IDLE; phase_reg <= 1'b0; bit_reg <= ISS_CNT_ZERO;
			sh_reg <= ISS_BYTE_ZERO; is_addr_reg <= 1'b0; ack_reg <= 1'b0;
			scl_oe_reg <= 1'b0; sda_oe_reg <= 1'b0; RDATA_OUT <= ISS_BYTE_ZERO;
			RDATA_VALID_OUT <= 1'b0; ADDR_NACK_OUT <= 1'b0; BUSY_OUT <= 1'b0;
		end else begin
			RDATA_VALID_OUT <= 1'b0;
			unique case (state_reg)
				ISM_IDLE: if (READ_REQ_IN) begin
					state_reg <= ISM_START; BUSY_OUT <= 1'b1; ADDR_NACK_OUT <= 1'b0;
					sh_reg <= {ADDR_IN, 1'b1}; is_addr_reg <= 1'b1; ack_reg <= ACK_BYTE_IN;
				end
				ISM_START: if (tick) begin
					if (!sda_oe_reg) begin
						sda_oe_reg <= 1'b1;             // Start: SDA falls with SCL high
					end else begin
						scl_oe_reg <= 1'b1; state_reg <= ISM_BITS; bit_reg <= ISS_CNT_ZERO;
						phase_reg <= 1'b0;
					end
				end
				ISM_BITS: if (tick) begin
					if (!phase_reg) begin
						// Low half: set SDA; release for slave data and our own ack sampling
						if (bit_reg < ISS_ACK_SLOT) begin
							sda_oe_reg <= is_addr_reg & ~sh_reg[ISS_BITS_PER_BYTE - 1];
						end else begin
							sda_oe_reg <= ~is_addr_reg & ack_reg;
						end
						scl_oe_reg <= 1'b0; phase_reg <= 1'b1;
					end else begin
						scl_oe_reg <= 1'b1; phase_reg <= 1'b0;
						if (bit_reg < ISS_ACK_SLOT) begin
							sh_reg <= {sh_reg[6:0], sda_s};
							bit_reg <= bit_reg + ISS_CNT_ONE;
						end else begin
							bit_reg <= ISS_CNT_ZERO;
							if (is_addr_reg) begin
								is_addr_reg <= 1'b0; ADDR_NACK_OUT <= sda_s;
								if (sda_s) state_reg <= ISM_STOP;
							end else begin
								RDATA_OUT <= sh_reg; RDATA_VALID_OUT <= 1'b1;
								if (!ack_reg || STOP_REQ_IN) state_reg <= ISM_STOP;
								ack_reg <= ACK_BYTE_IN;
							end
						end
					end
				end
				ISM_STOP: if (tick) begin
					if (scl_oe_reg) begin
						sda_oe_reg <= 1'b1; scl_oe_reg <= 1'b0;
					end else begin
						sda_oe_reg <= 1'b0; state_reg <= ISM_IDLE; BUSY_OUT <= 1'b0;
					end
				end
				default: state_reg <= ISM_IDLE;
			endcase
		end
	end
	assign BUS.mst_scl_oe = scl_oe_reg;
	assign BUS.mst_sda_oe = sda_oe_reg;
endmodule

// file: iss_chk_sva.sv
// Checker for the open-drain link between the slave and master ends.
// Assumes it watches the interface wires, sampled on the shared system clock.
`timescale 1ns/1ns
module iss_chk_sva (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	// Link enables and wire levels
	input wire logic slv_scl_oe,
	input wire logic slv_sda_oe,
	input wire logic mst_scl_oe,
	input wire logic mst_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	import iss_pkg::*;
	logic       scl_q, sda_q, ack_q;
	logic [3:0] bit_cnt;
	logic [1:0] byte_cnt;
	logic       start_ev, stop_ev, fall_ev, rise_ev;
	// ====================================
	// Bus events from the previous wire levels
	assign start_ev = scl && scl_q && !sda && sda_q;
	assign stop_ev  = scl && scl_q && sda && !sda_q;
	assign fall_ev  = !scl && scl_q;
	assign rise_ev  = scl && !scl_q;
	// Previous levels and the sampled answer of the ninth pulse
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			ack_q <= 1'b0;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (rise_ev && bit_cnt == ISS_ACK_SLOT) begin
				ack_q <= !sda;
			end
		end
	end
	// Bit position; F marks the fall that belongs to the Start itself
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			bit_cnt  <= 4'hF;
			byte_cnt <= 2'h0;
		end else if (start_ev) begin
			bit_cnt  <= 4'hF;
			byte_cnt <= 2'h0;
		end else if (fall_ev) begin
			if (bit_cnt == 4'hF || bit_cnt == ISS_ACK_SLOT) begin
				bit_cnt <= ISS_CNT_ZERO;
			end else begin
				bit_cnt <= bit_cnt + ISS_CNT_ONE;
			end
			if (bit_cnt == ISS_ACK_SLOT && byte_cnt != 2'h3) begin
				byte_cnt <= byte_cnt + 2'h1;
			end
		end
	end
	// ====================================
	// Assertions
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RESETN_IN);
	chk_slave_ack_release: assert property (
		(scl && byte_cnt != 2'h0 && bit_cnt == ISS_ACK_SLOT) |-> !slv_sda_oe)
		else $error("slave holds SDA in the master answer slot");
	chk_master_ack_release: assert property (
		(scl && byte_cnt == 2'h0 && bit_cnt == ISS_ACK_SLOT) |-> !mst_sda_oe)
		else $error("master holds SDA in the address answer slot");
	chk_master_data_free: assert property (
		(scl && ack_q && byte_cnt != 2'h0 && bit_cnt < ISS_ACK_SLOT) |-> !mst_sda_oe)
		else $error("master drives SDA during slave data");
	chk_sda_low_change: assert property (
		$changed(slv_sda_oe) |-> !scl)
		else $error("slave SDA changed while SCL high");
	chk_stretch_on_ack: assert property (
		(fall_ev && bit_cnt == ISS_ACK_SLOT && ack_q) |-> ##[1:6] slv_scl_oe)
		else $error("no clock stretch after acknowledge");
	chk_no_stretch_nack: assert property (
		(fall_ev && bit_cnt == ISS_ACK_SLOT && !ack_q) |=> !slv_scl_oe [*8])
		else $error("clock stretched after not-acknowledge");
	chk_stretch_low_only: assert property (
		$rose(slv_scl_oe) |-> !$past(scl))
		else $error("slave pulled SCL down during a high phase");
	chk_idle_after_stop: assert property (
		stop_ev |-> ##4 (!slv_sda_oe && !slv_scl_oe) [*4])
		else $error("slave still drives the bus after Stop");
	chk_stop_after_nack: assert property (
		(fall_ev && bit_cnt == ISS_ACK_SLOT && !ack_q) |-> ##[1:40] stop_ev)
		else $error("master did not end the read with Stop");
	// Main scenarios
	cov_start: cover property (start_ev);
	cov_data_ack: cover property (fall_ev && bit_cnt == ISS_ACK_SLOT && ack_q && byte_cnt != 2'h0);
	cov_stop: cover property (stop_ev);
endmodule

// file: i2c_slave_transmit_ack_bench.sv
// Bench joining the slave and master ends over the link interface.
// Assumes one 125 MHz clock for both ends; software is played by the tasks here.
`timescale 1ns/1ns
module i2c_slave_transmit_ack_bench;
	import iss_pkg::*;
	logic       clk, resetn;
	logic [6:0] own_addr, addr;
	logic       address_hold_enable, data_hold_enable, ack_data_value, ovf, sirq_en, slave_collision_detect_enable;
	logic       bwr, brd, rel_set, irq_clr, col_clr, rreq, ack_b, stop_r;
	logic [7:0] wdata, buf_out, rdata;
	logic       bf, ack_st, ack_tim, rd_st, st_st, rel, irq, bcl, rvalid, anack, busy;
	int         num_errors, comparisons;
	iss_bus_if iss_bus_if_i ();
	iss_slave iss_slave_i (.CLK_IN(clk), .RESETN_IN(resetn), .BUS(iss_bus_if_i.slave),
		.OWN_ADDR_IN(own_addr), .ADDRESS_HOLD_ENABLE_IN(address_hold_enable), .DATA_HOLD_ENABLE_IN(data_hold_enable),
		.ACK_DATA_VALUE_IN(ack_data_value), .SLAVE_COLLISION_DETECT_ENABLE_IN(slave_collision_detect_enable),
		.START_IRQ_ENABLE_IN(sirq_en), .RECEIVE_OVERFLOW_FLAG_IN(ovf), .BUF_WRITE_IN(bwr),
		.BUF_WDATA_IN(wdata), .BUF_READ_IN(brd), .CLOCK_RELEASE_SET_IN(rel_set),
		.IRQ_CLEAR_IN(irq_clr), .COLLISION_CLEAR_IN(col_clr), .SERIAL_DATA_BUFFER_OUT(buf_out),
		.BUFFER_FULL_FLAG_OUT(bf), .ACK_STATUS_OUT(ack_st), .ACK_TIME_STATUS_OUT(ack_tim),
		.READ_STATUS_OUT(rd_st), .START_STATUS_OUT(st_st), .CLOCK_RELEASE_OUT(rel),
		.SERIAL_PORT_IRQ_FLAG_OUT(irq), .BUS_COLLISION_IRQ_FLAG_OUT(bcl));
	iss_master iss_master_i (.CLK_IN(clk), .RESETN_IN(resetn), .BUS(iss_bus_if_i.master),
		.READ_REQ_IN(rreq), .ADDR_IN(addr), .ACK_BYTE_IN(ack_b), .STOP_REQ_IN(stop_r),
		.RDATA_OUT(rdata), .RDATA_VALID_OUT(rvalid), .ADDR_NACK_OUT(anack), .BUSY_OUT(busy));
	iss_chk_sva iss_chk_sva_i (.CLK_IN(clk), .RESETN_IN(resetn),
		.slv_scl_oe(iss_bus_if_i.slv_scl_oe), .slv_sda_oe(iss_bus_if_i.slv_sda_oe),
		.mst_scl_oe(iss_bus_if_i.mst_scl_oe), .mst_sda_oe(iss_bus_if_i.mst_sda_oe),
		.scl(iss_bus_if_i.scl), .sda(iss_bus_if_i.sda));
	// ====================================
	// Clock: 8 ns period
	always #4 clk = ~clk;
	// ====================================
	// Verdict and comparisons
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic check1(input string name, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %0b seen %0b", name, exp, got);
		end
	endtask
	task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Bounded wait; a pulse output stands through the following falling edge
	task automatic wait_lvl(ref logic s, input logic v, input string name);
		int n;
		n = 0;
		while (s !== v && n < 3000) begin
			@(negedge clk);
			n++;
		end
		check1(name, v, s);
		if (s !== v) end_sim();
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk) s = 1'b1;
		@(negedge clk) s = 1'b0;
	endtask
	// Master user side: one read request; busy is up by the task's end
	task automatic read_start(input logic [6:0] a, input logic ack, input logic stp);
		@(negedge clk);
		addr   = a;
		ack_b  = ack;
		stop_r = stp;
		rreq   = 1'b1;
		@(negedge clk) rreq = 1'b0;
		@(negedge clk);
	endtask
	// Slave software for one byte while stretched, then the master clocks it out.
	// The master takes its answer for a byte at the end of the byte before, so
	// ack is this byte's expected answer and nxt is handed on for the next byte.
	task automatic serve_byte(input logic [7:0] d, input logic ack, input logic stp,
	                          input logic nxt);
		wait_lvl(rel, 1'b0, "clock stretched");
		pulse(irq_clr);
		wdata = d;
		ack_b = nxt;
		stop_r = stp;
		pulse(bwr);
		pulse(rel_set);
		@(negedge clk);
		check1("clock release", 1'b1, rel);
		wait_lvl(rvalid, 1'b1, "read data valid");
		wait_lvl(irq, 1'b1, "byte irq flag");
		check8("read data", d, rdata);
		check1("ack status", !ack, ack_st);
	endtask
	// ====================================
	// Main sequence
	initial begin
		{clk, rreq, ack_b, stop_r, bwr, brd, rel_set, irq_clr, col_clr} = '0;
		{address_hold_enable, data_hold_enable, ack_data_value, ovf} = '0;
		{sirq_en, slave_collision_detect_enable} = 2'b11;
		own_addr = 7'h2C;
		addr = 7'h00;
		wdata = ISS_BYTE_ZERO;
		num_errors = 0;
		comparisons = 0;
		resetn = 1'b0;
		repeat (10) @(negedge clk);
		resetn = 1'b1;
		repeat (3) @(negedge clk);
		check1("clock release idle", 1'b1, rel);
		// Two-byte read: acked byte, then not-acknowledged last byte with Stop
		read_start(7'h2C, 1'b1, 1'b0);
		wait_lvl(st_st, 1'b1, "start status");
		check1("start irq", 1'b1, irq);
		pulse(irq_clr);
		wait_lvl(rel, 1'b0, "address stretch");
		check1("read status", 1'b1, rd_st);
		check8("address in buffer", 8'h59, buf_out);
		check1("buffer full", 1'b1, bf);
		check1("address irq", 1'b1, irq);
		check1("address nack", 1'b0, anack);
		check1("ack time without holds", 1'b0, ack_tim);
		pulse(brd);
		@(negedge clk);
		check1("buffer full after read", 1'b0, bf);
		serve_byte(8'hA5, 1'b1, 1'b0, 1'b0);
		serve_byte(8'h3C, 1'b0, 1'b1, 1'b0);
		wait_lvl(busy, 1'b0, "master done");
		check1("no stretch on nack", 1'b1, rel);
		// Refused addresses: mismatch, overflow, software nack under hold
		for (int i = 0; i < 3; i++) begin
			ovf   = (i == 1);
			address_hold_enable  = (i == 2);
			ack_data_value = (i == 2);
			read_start((i == 0) ? 7'h2D : 7'h2C, 1'b0, 1'b1);
			wait_lvl(busy, 1'b0, "refused read done");
			check1("refused address nack", 1'b1, anack);
			check1("refused no stretch", 1'b1, rel);
			pulse(brd);
		end
		// Hold enabled with software ack: ack-time status and one byte
		{ovf, ack_data_value, data_hold_enable} = 3'b001;
		read_start(7'h2C, 1'b0, 1'b1);
		wait_lvl(ack_tim, 1'b1, "ack time status");
		wait_lvl(rel, 1'b0, "held address stretch");
		check1("held address nack", 1'b0, anack);
		pulse(brd);
		serve_byte(8'hC3, 1'b0, 1'b1, 1'b0);
		wait_lvl(busy, 1'b0, "held read done");
		check1("collision flag quiet", 1'b0, bcl);
		end_sim();
	end
endmodule
